// File: logic/pad_group_drive.sv
// Output register stage for one pin group: data, enable and strength
`timescale 1ns/100ps
`default_nettype none

module pad_group_drive #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // From control logic
    input wire logic [WIDTH-1:0] i_data,
    input wire video_pad_pkg::pad_ctrl_s i_ctrl,
    // To pad cells
    output logic [WIDTH-1:0] o_data,
    output video_pad_pkg::pad_ctrl_s o_ctrl
);
    import video_pad_pkg::*;

    // Pin values registered so pads see glitch-free data
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            o_data <= '0;
        end
        else
        begin
            o_data <= i_data;
        end
    end

    // Enable and strength registered in step with the data
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            o_ctrl <= PAD_CTRL_RESET;
        end
        else
        begin
            o_ctrl <= i_ctrl;
        end
    end

endmodule // pad_group_drive

`default_nettype wire

// File: logic/video_output_pad_control.sv
// Global output pin control: three-state, drive strength and clock polarity
//
// Overview of operation
// - Global output disable at 1 three-states pixel data, hsync, vsync, field and subcarrier lock; 0 at reset.
// - Timing output force at 1 keeps hsync, vsync and field driven despite the global disable; 0 at reset.
// - Clock output disable at 1 three-states the line-locked clock; at 0 it drives at the clock strength.
// - Pixel data drivers take a 2-bit strength code 00=1x 01=2x 10=3x 11=4x, resetting to 2x.
// - Line-locked clock driver takes its own 2-bit strength code of the same encoding, resetting to 2x.
// - Hsync, vsync and field drivers take a third strength code, also applied while forced active.
// - Subcarrier lock pin enable at 1 presents lock information on its pin; 0 at reset disables it.
// - Clock polarity bit at 1 (reset) gives a normal line-locked clock, at 0 an inverted one.
`timescale 1ns/100ps
`default_nettype none

module video_output_pad_control (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Register port from the serial host interface
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // Video values from the processing core
    input wire logic [15:0] i_pixel_data,
    input wire logic i_horizontal_sync,
    input wire logic i_vertical_sync,
    input wire logic i_field,
    input wire logic i_subcarrier_lock,
    input wire logic i_line_locked_clock,
    // Pixel data pins
    output logic [15:0] o_pixel_data_out,
    output video_pad_pkg::pad_ctrl_s o_pixel_ctrl,
    // Timing pins: hsync, vsync, field
    output logic o_horizontal_sync_out,
    output logic o_vertical_sync_out,
    output logic o_field_out,
    output video_pad_pkg::pad_ctrl_s o_timing_ctrl,
    // Subcarrier lock pin
    output logic o_subcarrier_lock_out,
    output video_pad_pkg::pad_ctrl_s o_subcarrier_lock_ctrl,
    // Line-locked clock pin
    output logic o_line_locked_clock_out,
    output video_pad_pkg::pad_ctrl_s o_clock_ctrl
);
    import video_pad_pkg::*;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [7:0] output_disable_ctrl_ff;
    logic [7:0] timing_output_ctrl_ff;
    logic [7:0] clock_sync_drive_ctrl_ff;
    logic [7:0] clock_polarity_ctrl_ff;
    logic [7:0] nxt_rdata;

    // Unused bits are kept as plain storage so software reads back what it wrote
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            output_disable_ctrl_ff <= RST_OUTPUT_DISABLE_CTRL;
            timing_output_ctrl_ff <= RST_TIMING_OUTPUT_CTRL;
            clock_sync_drive_ctrl_ff <= RST_CLOCK_SYNC_DRIVE_CTRL;
            clock_polarity_ctrl_ff <= RST_CLOCK_POLARITY_CTRL;
        end
        else if (i_reg_wr)
        begin
            unique case (i_reg_addr)
                ADDR_OUTPUT_DISABLE_CTRL: output_disable_ctrl_ff <= i_reg_wdata;
                ADDR_TIMING_OUTPUT_CTRL: timing_output_ctrl_ff <= i_reg_wdata;
                ADDR_CLOCK_SYNC_DRIVE_CTRL: clock_sync_drive_ctrl_ff <= i_reg_wdata;
                ADDR_CLOCK_POLARITY_CTRL: clock_polarity_ctrl_ff <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    // Read mux; other addresses belong to other blocks and read as zero here
    always_comb
    begin
        unique case (i_reg_addr)
            ADDR_OUTPUT_DISABLE_CTRL: nxt_rdata = output_disable_ctrl_ff;
            ADDR_TIMING_OUTPUT_CTRL: nxt_rdata = timing_output_ctrl_ff;
            ADDR_CLOCK_SYNC_DRIVE_CTRL: nxt_rdata = clock_sync_drive_ctrl_ff;
            ADDR_CLOCK_POLARITY_CTRL: nxt_rdata = clock_polarity_ctrl_ff;
            default: nxt_rdata = UNMAPPED_READ_VALUE;
        endcase
    end

    // Read data registered, valid one cycle after the request
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            o_reg_rdata <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end
        else
        begin
            o_reg_rdata <= i_reg_rd ? nxt_rdata : o_reg_rdata;
            o_reg_rvalid <= i_reg_rd;
        end
    end

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    // Strength field extraction, shared by the three pin groups
    function automatic drive_strength_e strength_field(input logic [7:0] reg_value, input int lsb);
        strength_field = drive_strength_e'(reg_value[lsb +: 2]);
    endfunction

    // One enable per group: own enable, global disable and an override
    function automatic logic group_enable(input logic enable, input logic disable_all, input logic force_on);
        group_enable = enable & (~disable_all | force_on);
    endfunction

    logic global_output_disable;
    logic timing_output_force;
    logic subcarrier_lock_pin_enable;
    logic clock_output_disable;
    logic clock_polarity_normal;

    assign global_output_disable = output_disable_ctrl_ff[GLOBAL_OUTPUT_DISABLE_BIT];
    assign timing_output_force = timing_output_ctrl_ff[TIMING_OUTPUT_FORCE_BIT];
    assign subcarrier_lock_pin_enable = timing_output_ctrl_ff[SUBCARRIER_LOCK_PIN_ENABLE_BIT];
    assign clock_output_disable = clock_sync_drive_ctrl_ff[CLOCK_OUTPUT_DISABLE_BIT];
    assign clock_polarity_normal = clock_polarity_ctrl_ff[CLOCK_POLARITY_BIT];

    // ------------------------------------------------------------
    // Pin group control
    // ------------------------------------------------------------
    pad_ctrl_s pixel_ctrl;
    pad_ctrl_s timing_ctrl;
    pad_ctrl_s lock_pin_ctrl;
    pad_ctrl_s clock_ctrl;
    logic clock_value;

    // Enables merged per group, strength codes passed through untouched
    always_comb
    begin
        pixel_ctrl.oe = group_enable(1'b1, global_output_disable, 1'b0);
        pixel_ctrl.strength = strength_field(timing_output_ctrl_ff, DATA_DRIVE_STRENGTH_LSB);
        timing_ctrl.oe = group_enable(1'b1, global_output_disable, timing_output_force);
        timing_ctrl.strength = strength_field(clock_sync_drive_ctrl_ff, SYNC_DRIVE_STRENGTH_LSB);
        lock_pin_ctrl.oe = group_enable(subcarrier_lock_pin_enable, global_output_disable, 1'b0);
        lock_pin_ctrl.strength = pixel_ctrl.strength;
        clock_ctrl.oe = ~clock_output_disable;
        clock_ctrl.strength = strength_field(clock_sync_drive_ctrl_ff, CLOCK_DRIVE_STRENGTH_LSB);
    end

    // Polarity applied before the output flop, so the pin stays registered
    assign clock_value = clock_polarity_normal ? i_line_locked_clock : ~i_line_locked_clock;

    // ------------------------------------------------------------
    // Output stages
    // ------------------------------------------------------------
    pad_group_drive #(.WIDTH(16)) u_pixel_pads (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_data(i_pixel_data),
        .i_ctrl(pixel_ctrl),
        .o_data(o_pixel_data_out),
        .o_ctrl(o_pixel_ctrl)
    );

    pad_group_drive #(.WIDTH(3)) u_timing_pads (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_data({i_horizontal_sync, i_vertical_sync, i_field}),
        .i_ctrl(timing_ctrl),
        .o_data({o_horizontal_sync_out, o_vertical_sync_out, o_field_out}),
        .o_ctrl(o_timing_ctrl)
    );

    // Subcarrier lock shares the pixel strength; no separate code exists
    pad_group_drive #(.WIDTH(1)) u_lock_pad (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_data(i_subcarrier_lock),
        .i_ctrl(lock_pin_ctrl),
        .o_data(o_subcarrier_lock_out),
        .o_ctrl(o_subcarrier_lock_ctrl)
    );

    pad_group_drive #(.WIDTH(1)) u_clock_pad (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_data(clock_value),
        .i_ctrl(clock_ctrl),
        .o_data(o_line_locked_clock_out),
        .o_ctrl(o_clock_ctrl)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    logic past_valid_ff;

    // Blocks checks on the first cycle after reset, before the pads settle
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            past_valid_ff <= 1'b0;
        end
        else
        begin
            past_valid_ff <= 1'b1;
        end
    end

    property p_pixel_oe;
        past_valid_ff |-> o_pixel_ctrl.oe == !$past(output_disable_ctrl_ff[GLOBAL_OUTPUT_DISABLE_BIT]);
    endproperty
    a_pixel_oe: assert property (p_pixel_oe) else $error("pixel enable wrong");

    property p_timing_force;
        past_valid_ff && $past(timing_output_ctrl_ff[TIMING_OUTPUT_FORCE_BIT]) |-> o_timing_ctrl.oe;
    endproperty
    a_timing_force: assert property (p_timing_force) else $error("timing pins not forced");

    property p_timing_follow;
        past_valid_ff && !$past(timing_output_ctrl_ff[TIMING_OUTPUT_FORCE_BIT])
            |-> o_timing_ctrl.oe == o_pixel_ctrl.oe;
    endproperty
    a_timing_follow: assert property (p_timing_follow) else $error("timing pins ignore disable");

    property p_clock_oe;
        i_reg_wr && i_reg_addr == ADDR_CLOCK_SYNC_DRIVE_CTRL
            |-> ##2 o_clock_ctrl.oe == !$past(i_reg_wdata[CLOCK_OUTPUT_DISABLE_BIT], 2);
    endproperty
    a_clock_oe: assert property (p_clock_oe) else $error("clock enable wrong");

    property p_data_strength;
        i_reg_wr && i_reg_addr == ADDR_TIMING_OUTPUT_CTRL
            |-> ##2 o_pixel_ctrl.strength == $past(i_reg_wdata[DATA_DRIVE_STRENGTH_LSB +: 2], 2);
    endproperty
    a_data_strength: assert property (p_data_strength) else $error("data strength wrong");

    property p_clock_strength;
        past_valid_ff |-> o_clock_ctrl.strength == $past(clock_sync_drive_ctrl_ff[CLOCK_DRIVE_STRENGTH_LSB +: 2]);
    endproperty
    a_clock_strength: assert property (p_clock_strength) else $error("clock strength wrong");

    property p_sync_strength;
        past_valid_ff |-> o_timing_ctrl.strength == $past(clock_sync_drive_ctrl_ff[SYNC_DRIVE_STRENGTH_LSB +: 2]);
    endproperty
    a_sync_strength: assert property (p_sync_strength) else $error("sync strength wrong");

    property p_lock_enable;
        past_valid_ff |-> o_subcarrier_lock_ctrl.oe == ($past(subcarrier_lock_pin_enable)
            && !$past(global_output_disable));
    endproperty
    a_lock_enable: assert property (p_lock_enable) else $error("lock pin enable wrong");

    property p_clock_polarity;
        past_valid_ff |-> o_line_locked_clock_out
            == ($past(i_line_locked_clock) ^ !$past(clock_polarity_ctrl_ff[CLOCK_POLARITY_BIT]));
    endproperty
    a_clock_polarity: assert property (p_clock_polarity) else $error("clock polarity wrong");

    property p_data_passthrough;
        past_valid_ff |-> o_pixel_data_out == $past(i_pixel_data);
    endproperty
    a_data_passthrough: assert property (p_data_passthrough) else $error("pixel data altered");

    property p_timing_passthrough;
        past_valid_ff |-> {o_horizontal_sync_out, o_vertical_sync_out, o_field_out}
            == $past({i_horizontal_sync, i_vertical_sync, i_field});
    endproperty
    a_timing_passthrough: assert property (p_timing_passthrough) else $error("timing values altered");

    property p_lock_passthrough;
        past_valid_ff |-> o_subcarrier_lock_out == $past(i_subcarrier_lock);
    endproperty
    a_lock_passthrough: assert property (p_lock_passthrough) else $error("lock value altered");

    // Lock pin has no code of its own, so it must track the data field
    property p_lock_strength;
        past_valid_ff |-> o_subcarrier_lock_ctrl.strength
            == $past(timing_output_ctrl_ff[DATA_DRIVE_STRENGTH_LSB +: 2]);
    endproperty
    a_lock_strength: assert property (p_lock_strength) else $error("lock strength wrong");

    property p_read_valid;
        past_valid_ff |-> o_reg_rvalid == $past(i_reg_rd);
    endproperty
    a_read_valid: assert property (p_read_valid) else $error("read valid timing wrong");

    c_forced_timing: cover property (o_timing_ctrl.oe && !o_pixel_ctrl.oe);
    c_clock_inverted: cover property (!clock_polarity_normal ##1 o_clock_ctrl.oe);
    c_lock_driven: cover property (o_subcarrier_lock_ctrl.oe);
    c_all_off: cover property (!o_pixel_ctrl.oe && !o_timing_ctrl.oe && !o_clock_ctrl.oe);

endmodule // video_output_pad_control

`default_nettype wire

// File: logic/video_pad_pkg.sv
// Shared constants and carrier types for the video output pad control block
package video_pad_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_OUTPUT_DISABLE_CTRL = 8'h03;
    localparam logic [7:0] ADDR_TIMING_OUTPUT_CTRL = 8'h04;
    localparam logic [7:0] ADDR_CLOCK_SYNC_DRIVE_CTRL = 8'h0e;
    localparam logic [7:0] ADDR_CLOCK_POLARITY_CTRL = 8'h37;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int GLOBAL_OUTPUT_DISABLE_BIT = 6;
    localparam int TIMING_OUTPUT_FORCE_BIT = 3;
    localparam int SUBCARRIER_LOCK_PIN_ENABLE_BIT = 1;
    localparam int DATA_DRIVE_STRENGTH_LSB = 4;
    localparam int CLOCK_OUTPUT_DISABLE_BIT = 6;
    localparam int CLOCK_DRIVE_STRENGTH_LSB = 2;
    localparam int SYNC_DRIVE_STRENGTH_LSB = 0;
    localparam int CLOCK_POLARITY_BIT = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_OUTPUT_DISABLE_CTRL = 8'h00;
    localparam logic [7:0] RST_TIMING_OUTPUT_CTRL = 8'h10;
    localparam logic [7:0] RST_CLOCK_SYNC_DRIVE_CTRL = 8'h05;
    localparam logic [7:0] RST_CLOCK_POLARITY_CTRL = 8'h01;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    // ------------------------------------------------------------
    // Drive strength codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DRIVE_1X = 2'h0,
        DRIVE_2X = 2'h1,
        DRIVE_3X = 2'h2,
        DRIVE_4X = 2'h3
    } drive_strength_e;

    // Per pin group pad control carried to the pad cells
    typedef struct packed {
        logic oe;
        drive_strength_e strength;
    } pad_ctrl_s;

    localparam pad_ctrl_s PAD_CTRL_RESET = '{oe: 1'b0, strength: DRIVE_1X};

endpackage

// File: sim/tb_top.sv
// Self-checking bench for the video output pad control block
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import video_pad_pkg::*;

    // ----
    // Signals
    // ----
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic [20:0] video_in = 21'h0; // {pixel, hsync, vsync, field, lock, clock}
    logic [15:0] pix_out;
    logic [2:0] tim_out;
    logic lock_out;
    logic clk_out;
    pad_ctrl_s pix_ctrl, tim_ctrl, lock_ctrl, clk_ctrl;
    logic capture = 1'b0;
    logic seen_valid;
    logic [32:0] seen;
    logic [31:0] seed = 32'h09c8;
    logic [7:0] addrs [4] = '{ADDR_OUTPUT_DISABLE_CTRL, ADDR_TIMING_OUTPUT_CTRL, ADDR_CLOCK_SYNC_DRIVE_CTRL,
        ADDR_CLOCK_POLARITY_CTRL};
    logic [7:0] regs [4];
    logic [7:0] rq [$];
    logic [32:0] pq [$];
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    always #12.5 i_clk_sys = ~i_clk_sys;

    video_output_pad_control i_video_output_pad_control (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
        .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid),
        .i_pixel_data(video_in[20:5]), .i_horizontal_sync(video_in[4]), .i_vertical_sync(video_in[3]),
        .i_field(video_in[2]), .i_subcarrier_lock(video_in[1]), .i_line_locked_clock(video_in[0]),
        .o_pixel_data_out(pix_out), .o_pixel_ctrl(pix_ctrl), .o_horizontal_sync_out(tim_out[2]),
        .o_vertical_sync_out(tim_out[1]), .o_field_out(tim_out[0]), .o_timing_ctrl(tim_ctrl),
        .o_subcarrier_lock_out(lock_out), .o_subcarrier_lock_ctrl(lock_ctrl),
        .o_line_locked_clock_out(clk_out), .o_clock_ctrl(clk_ctrl));

    video_backend_model i_video_backend_model (
        .i_clk_sys(i_clk_sys), .i_capture(capture), .i_pixel_data_out(pix_out), .i_pixel_ctrl(pix_ctrl),
        .i_timing_out(tim_out), .i_timing_ctrl(tim_ctrl), .i_lock_out(lock_out), .i_lock_ctrl(lock_ctrl),
        .i_clock_out(clk_out), .i_clock_ctrl(clk_ctrl), .o_seen_valid(seen_valid), .o_seen(seen));

    // ----
    // Helpers
    // ----
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected pins from the shadow registers and the sampled video
    function automatic logic [32:0] exp_pins(input logic [20:0] v);
        logic [2:0] pc, tc, sc, cc;
        logic [20:0] w;
        pc = {!regs[0][6], regs[1][5:4]};
        tc = {!regs[0][6] || regs[1][3], regs[2][1:0]};
        sc = {regs[1][1] && !regs[0][6], regs[1][5:4]};
        cc = {!regs[2][6], regs[2][3:2]};
        w[20:5] = pc[2] ? v[20:5] : 16'hzzzz;
        w[4:2] = tc[2] ? v[4:2] : 3'bzzz;
        w[1] = sc[2] ? v[1] : 1'bz;
        w[0] = cc[2] ? (v[0] ^ !regs[3][0]) : 1'bz;
        return {pc, tc, sc, cc, w};
    endfunction

    task automatic fail(input string msg);
        $display("FAIL at %0t: %s", $time, msg);
        n_errors++;
    endtask

    task automatic print_verdict();
        if (rq.size() != 0 || pq.size() != 0)
            fail("requests left unanswered");
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One register access; one idle cycle follows each strobe
    task automatic reg_op(input logic wr, input logic rd, input logic [7:0] addr, input logic [7:0] wdata,
        input logic [7:0] exp);
        @(negedge i_clk_sys);
        reg_wr = wr;
        reg_rd = rd;
        reg_addr = addr;
        reg_wdata = wdata;
        if (rd)
            rq.push_back(exp);
        @(negedge i_clk_sys);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    endtask

    task automatic wr_reg(input int idx, input logic [7:0] val);
        reg_op(1'b1, 1'b0, addrs[idx], val, 8'h00);
        regs[idx] = val;
    endtask

    // Hold random video for one sample, then ask the back-end to look
    task automatic check_pads();
        logic [20:0] v;
        seed = lfsr_next(seed);
        v = seed[20:0];
        @(negedge i_clk_sys);
        video_in = v;
        @(negedge i_clk_sys);
        capture = 1'b1;
        pq.push_back(exp_pins(v));
        @(negedge i_clk_sys);
        capture = 1'b0;
    endtask

    task automatic do_reset();
        @(negedge i_clk_sys);
        i_rst = 1'b1;
        repeat (2) @(negedge i_clk_sys);
        i_rst = 1'b0;
        regs = '{RST_OUTPUT_DISABLE_CTRL, RST_TIMING_OUTPUT_CTRL, RST_CLOCK_SYNC_DRIVE_CTRL, RST_CLOCK_POLARITY_CTRL};
    endtask

    // ----
    // Monitors: oldest note against each result
    // ----
    always @(negedge i_clk_sys)
    begin
        if (reg_rvalid === 1'b1)
        begin
            n_compared++;
            if (rq.size() == 0)
                fail("read data without request");
            else if (reg_rdata !== rq.pop_front())
                fail("register read mismatch");
        end
        if (seen_valid === 1'b1)
        begin
            n_compared++;
            if (pq.size() == 0)
                fail("pin sample without request");
            else if (seen !== pq.pop_front())
                fail("pin state mismatch");
        end
    end

    // Hang guard, the run needs well under a thousand cycles
    always @(posedge i_clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail("timeout");
            print_verdict();
        end
    end

    // ----
    // Main sequence
    // ----
    initial
    begin
        do_reset();
        for (int k = 0; k < 4; k++)
            reg_op(1'b0, 1'b1, addrs[k], 8'h00, regs[k]);
        reg_op(1'b0, 1'b1, 8'h11, 8'h00, UNMAPPED_READ_VALUE);
        check_pads();
        // Every disable and force combination, every strength code
        for (int i = 0; i < 16; i++)
        begin
            seed = lfsr_next(seed);
            wr_reg(0, {seed[7], i[0], seed[5:0]});
            wr_reg(1, {seed[15:14], i[3:2], i[1], seed[10], i[2] ^ i[0], seed[8]});
            wr_reg(2, {seed[23], i[1] ^ i[3], seed[21:20], i[3:2], i[1:0]});
            wr_reg(3, {seed[31:25], i[0] ^ i[2] ^ i[3]});
            reg_op(1'b0, 1'b1, addrs[i % 4], 8'h00, regs[i % 4]);
            check_pads();
        end
        // Unmapped write is dropped and reads back zero
        reg_op(1'b1, 1'b0, 8'h05, 8'hff, 8'h00);
        reg_op(1'b0, 1'b1, 8'h05, 8'h00, UNMAPPED_READ_VALUE);
        // Read in the write cycle sees the old value
        reg_op(1'b1, 1'b1, addrs[1], 8'h5a, regs[1]);
        regs[1] = 8'h5a;
        reg_op(1'b0, 1'b1, addrs[1], 8'h00, 8'h5a);
        check_pads();
        // Reset in mid-run restores the defaults
        do_reset();
        check_pads();
        reg_op(1'b0, 1'b1, addrs[2], 8'h00, RST_CLOCK_SYNC_DRIVE_CTRL);
        repeat (3) @(negedge i_clk_sys);
        print_verdict();
    end
endmodule // tb_top

`default_nettype wire

// File: sim/video_backend_model.sv
// Downstream back-end model: samples the video pins as a receiver sees them
`timescale 1ns/100ps
`default_nettype none

module video_backend_model (
    // Clock and capture request
    input wire logic i_clk_sys,
    input wire logic i_capture,
    // Pins and pad controls from the decoder
    input wire logic [15:0] i_pixel_data_out,
    input wire video_pad_pkg::pad_ctrl_s i_pixel_ctrl,
    input wire logic [2:0] i_timing_out,
    input wire video_pad_pkg::pad_ctrl_s i_timing_ctrl,
    input wire logic i_lock_out,
    input wire video_pad_pkg::pad_ctrl_s i_lock_ctrl,
    input wire logic i_clock_out,
    input wire video_pad_pkg::pad_ctrl_s i_clock_ctrl,
    // Captured view: {pad controls, wire levels}
    output logic o_seen_valid,
    output logic [32:0] o_seen
);
    import video_pad_pkg::*;

    logic [20:0] wire_level;

    // ----
    // Wire levels
    // ----
    // Released pins float; a stale value must never pass for a driven one
    assign wire_level[20:5] = i_pixel_ctrl.oe ? i_pixel_data_out : 16'hzzzz;
    assign wire_level[4:2] = i_timing_ctrl.oe ? i_timing_out : 3'bzzz;
    assign wire_level[1] = i_lock_ctrl.oe ? i_lock_out : 1'bz;
    assign wire_level[0] = i_clock_ctrl.oe ? i_clock_out : 1'bz;

    // Sample every cycle, valid marks a request; strengths as seen by the pad cells
    always_ff @(posedge i_clk_sys)
    begin
        o_seen_valid <= i_capture;
        o_seen <= {i_pixel_ctrl, i_timing_ctrl, i_lock_ctrl, i_clock_ctrl, wire_level};
    end
endmodule // video_backend_model

`default_nettype wire
